// ### design/vcp_pkg.sv
package vcp_pkg;
	// geometry and plane indices
	localparam int unsigned DIM_W        = 12;
	localparam int unsigned PLANES       = 3;
	localparam int unsigned PL_Y         = 0;
	localparam int unsigned PL_U         = 1;
	localparam int unsigned PL_V         = 2;
	// register byte offsets
	localparam logic [11:0] OFS_CONTROL    = 12'h000;
	localparam logic [11:0] OFS_STATUS     = 12'h004;
	localparam logic [11:0] OFS_CAP_START  = 12'h008;
	localparam logic [11:0] OFS_CAP_SIZE   = 12'h00C;
	localparam logic [11:0] OFS_BASE_Y     = 12'h010;
	localparam logic [11:0] OFS_STEP_Y     = 12'h014;
	localparam logic [11:0] OFS_PLANE_STEP = 12'h008;
	localparam logic [11:0] OFS_LINE_ALERT = 12'h028;
	// capture_control_reg fields
	localparam int unsigned CB_ENABLE    = 0;
	localparam int unsigned CB_LITTLE    = 1;
	localparam int unsigned CB_HALFRES   = 2;
	localparam int unsigned CB_SITING    = 3;
	localparam int unsigned CB_IE_DONE   = 4;
	localparam int unsigned CB_IE_ALERT  = 5;
	localparam int unsigned CB_IE_FAULT  = 6;
	localparam int unsigned CB_ACK_DONE  = 8;
	localparam int unsigned CB_ACK_ALERT = 9;
	localparam int unsigned CB_ACK_FAULT = 10;
	localparam int unsigned CTL_W        = 7;
	localparam logic [6:0]  CTL_RST      = 7'h00;
	// capture_status_reg fields
	localparam int unsigned ST_DONE      = 0;
	localparam int unsigned ST_ALERT     = 1;
	localparam int unsigned ST_FAULT     = 2;
	localparam int unsigned ST_SECOND_FIELD_FLAG    = 3;
	localparam int unsigned ST_LINE_LSB  = 16;
	// base alignment and sample clamp
	localparam logic [31:0] ALIGN_MASK   = 32'h0000_003F;
	localparam logic [7:0]  SAT_MIN      = 8'h01;
	localparam logic [7:0]  SAT_MAX      = 8'hFF;
	// timing reference code
	localparam logic [7:0]  TRS_ONES     = 8'hFF;
	localparam logic [7:0]  TRS_ZERO     = 8'h00;
	localparam int unsigned TRS_F        = 6;
	localparam int unsigned TRS_V        = 5;
	localparam int unsigned TRS_H        = 4;
	// write completion bound after a line alert
	localparam int unsigned SYS_CLK_NS          = 10;
	localparam int unsigned LINE_ALERT_DRAIN_NS = 2000;
	localparam int unsigned LINE_ALERT_DRAIN_CYC = LINE_ALERT_DRAIN_NS / SYS_CLK_NS;

	typedef enum logic [2:0] {
		CAP_IDLE, CAP_WAIT_LINE, CAP_IN_LINE, CAP_EOL1, CAP_EOL2, CAP_LINE_END, CAP_DRAIN
	} vcp_cap_state_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0]  be;
	} vcp_word_t;
endpackage

// ### design/vcp_capture.sv
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module vcp_capture (
	// system
	input  wire logic               clk_sys,
	input  wire logic               rst_b,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// camera pins
	input  wire logic               vid_clk,
	input  wire logic               vid_dvalid,
	input  wire logic [7:0]         vid_data,
	// memory write port
	output logic                    mem_req,
	output vcp_pkg::vcp_word_t      mem_word,
	input  wire logic               mem_ack,
	// interrupt request
	output logic                    irq
);
	localparam int ALERT_DRAIN_CYC = int'(vcp_pkg::LINE_ALERT_DRAIN_CYC);
	localparam int DW = vcp_pkg::DIM_W;

	function automatic logic [11:0] base_ofs(input int unsigned p);
		base_ofs = vcp_pkg::OFS_BASE_Y + 12'(p * vcp_pkg::OFS_PLANE_STEP);
	endfunction

	function automatic logic [11:0] step_ofs(input int unsigned p);
		step_ofs = vcp_pkg::OFS_STEP_Y + 12'(p * vcp_pkg::OFS_PLANE_STEP);
	endfunction

	function automatic logic [7:0] avg_sat(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b} + 9'h001;
		avg_sat = (s[8:1] < vcp_pkg::SAT_MIN) ? vcp_pkg::SAT_MIN : s[8:1];
	endfunction

	// (-1 13 5 -1)/16 midway chroma, full precision then clamp
	function automatic logic [7:0] filt4(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] c, input logic [7:0] d);
		logic signed [13:0] s;
		logic signed [13:0] q;
		s = $signed({6'h00, b}) * 14'sh000D + $signed({6'h00, c}) * 14'sh0005
			- $signed({6'h00, a}) - $signed({6'h00, d}) + 14'sh0008;
		q = s >>> 4;
		if (q < 14'sh0001)
			filt4 = vcp_pkg::SAT_MIN;
		else if (q > 14'sh00FF)
			filt4 = vcp_pkg::SAT_MAX;
		else
			filt4 = q[7:0];
	endfunction

	// pins pass two flops before anything looks at them
	logic [9:0]  pin_meta;
	logic [9:0]  pin_sync;
	logic        pclk_prev;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pin_meta  <= '0;
			pin_sync  <= '0;
			pclk_prev <= 1'b0;
		end else begin
			pin_meta  <= {vid_clk, vid_dvalid, vid_data};
			pin_sync  <= pin_meta;
			pclk_prev <= pin_sync[9];
		end
	end
	wire       byte_stb = pin_sync[9] & ~pclk_prev & pin_sync[8];
	wire [7:0] byte_in  = pin_sync[7:0];

	// registers
	logic [6:0]    control;
	logic [31:0]   base_adr [3];
	logic [15:0]   line_step [3];
	logic [DW-1:0] start_x;
	logic [DW-1:0] start_y;
	logic [DW-1:0] cap_width;
	logic [DW-1:0] cap_height;
	logic [DW-1:0] line_alert;
	logic          done_flag;
	logic          alert_flag;
	logic          bandwidth_fault_flag;
	logic          second_field_flag;
	logic [DW-1:0] current_line_index;

	wire ctl_en      = control[vcp_pkg::CB_ENABLE];
	wire ctl_little  = control[vcp_pkg::CB_LITTLE];
	wire ctl_halfres = control[vcp_pkg::CB_HALFRES];
	wire chroma_siting_select = control[vcp_pkg::CB_SITING];

	wire apb_wr    = psel & penable & pwrite;
	wire ctl_wr    = apb_wr && paddr == vcp_pkg::OFS_CONTROL;
	wire ack_done  = ctl_wr & pwdata[vcp_pkg::CB_ACK_DONE];
	wire ack_alert = ctl_wr & pwdata[vcp_pkg::CB_ACK_ALERT];
	wire ack_fault = ctl_wr & pwdata[vcp_pkg::CB_ACK_FAULT];

	wire [31:0] status_word = {4'h0, current_line_index, 12'h000, second_field_flag,
		bandwidth_fault_flag, alert_flag, done_flag};

	logic [31:0] rd_mux;
	logic        rd_hit;
	always_comb begin
		rd_mux = '0;
		rd_hit = 1'b1;
		if (paddr == vcp_pkg::OFS_CONTROL)
			rd_mux[6:0] = control;
		else if (paddr == vcp_pkg::OFS_STATUS)
			rd_mux = status_word;
		else if (paddr == vcp_pkg::OFS_CAP_START)
			rd_mux = {4'h0, start_y, 4'h0, start_x};
		else if (paddr == vcp_pkg::OFS_CAP_SIZE)
			rd_mux = {4'h0, cap_height, 4'h0, cap_width};
		else if (paddr == vcp_pkg::OFS_LINE_ALERT)
			rd_mux = {20'h0_0000, line_alert};
		else
			rd_hit = 1'b0;
		for (int unsigned p = 0; p < vcp_pkg::PLANES; p++) begin
			if (paddr == base_ofs(p)) begin
				rd_mux = base_adr[p];
				rd_hit = 1'b1;
			end
			if (paddr == step_ofs(p)) begin
				rd_mux = {16'h0000, line_step[p]};
				rd_hit = 1'b1;
			end
		end
	end

	// zero-wait slave: read data is latched in the setup cycle
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~rd_hit;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			control    <= vcp_pkg::CTL_RST;
			start_x    <= '0;
			start_y    <= '0;
			cap_width  <= '0;
			cap_height <= '0;
			line_alert <= '0;
			prdata     <= '0;
			for (int unsigned p = 0; p < vcp_pkg::PLANES; p++) begin
				base_adr[p]  <= '0;
				line_step[p] <= '0;
			end
		end else begin
			if (psel && !penable)
				prdata <= rd_mux;
			if (apb_wr) begin
				if (paddr == vcp_pkg::OFS_CONTROL)
					control <= pwdata[vcp_pkg::CTL_W-1:0];
				if (paddr == vcp_pkg::OFS_CAP_START) begin
					start_x <= pwdata[DW-1:0];
					start_y <= pwdata[DW+15:16];
				end
				if (paddr == vcp_pkg::OFS_CAP_SIZE) begin
					cap_width  <= pwdata[DW-1:0];
					cap_height <= pwdata[DW+15:16];
				end
				if (paddr == vcp_pkg::OFS_LINE_ALERT)
					line_alert <= pwdata[DW-1:0];
				for (int unsigned p = 0; p < vcp_pkg::PLANES; p++) begin
					if (paddr == base_ofs(p))
						base_adr[p] <= pwdata & ~vcp_pkg::ALIGN_MASK;
					if (paddr == step_ofs(p))
						line_step[p] <= pwdata[15:0];
				end
			end
		end
	end

	// stream parser: timing codes, line index, field
	logic [7:0]    hist0;
	logic [7:0]    hist1;
	logic [7:0]    hist2;
	logic          v_prev;
	logic [1:0]    ph;
	logic [DW-1:0] px;
	wire is_trs = hist2 == vcp_pkg::TRS_ONES && hist1 == vcp_pkg::TRS_ZERO
		&& hist0 == vcp_pkg::TRS_ZERO;
	wire trs_stb      = byte_stb & is_trs;
	wire is_sav       = trs_stb & ~byte_in[vcp_pkg::TRS_H];
	wire vblank_start = trs_stb & byte_in[vcp_pkg::TRS_V] & ~v_prev;
	wire [DW-1:0] next_line = (~byte_in[vcp_pkg::TRS_V] & v_prev) ? '0
		: current_line_index + 1'b1;
	wire alert_evt = is_sav && next_line == line_alert;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hist0              <= '0;
			hist1              <= '0;
			hist2              <= '0;
			v_prev             <= 1'b0;
			ph                 <= '0;
			px                 <= '0;
			current_line_index <= '0;
			second_field_flag  <= 1'b0;
		end else if (byte_stb) begin
			hist0 <= byte_in;
			hist1 <= hist0;
			hist2 <= hist1;
			if (trs_stb) begin
				v_prev <= byte_in[vcp_pkg::TRS_V];
				if (!byte_in[vcp_pkg::TRS_H]) begin
					ph                 <= '0;
					px                 <= '0;
					current_line_index <= next_line;
				end
				// field flag at vertical blanking start
				if (vblank_start)
					second_field_flag <= byte_in[vcp_pkg::TRS_F];
			end else begin
				ph <= ph + 2'd1;
				if (ph == 2'd3)
					px <= px + DW'(2);
			end
		end
	end

	// capture sequencing
	vcp_pkg::vcp_cap_state_t state;
	logic [DW-1:0] lines_left;
	logic [DW:0]   bytes_left;
	logic [1:0]    cph;
	logic [2:0]    pend_v;
	logic [3:0]    be_acc [3];
	wire drained = pend_v == 3'b000 && !mem_req && be_acc[0] == 4'h0
		&& be_acc[1] == 4'h0 && be_acc[2] == 4'h0;
	wire cap_start = state == vcp_pkg::CAP_IDLE && ctl_en && !done_flag && is_sav
		&& next_line == start_y;
	wire line_go  = state == vcp_pkg::CAP_WAIT_LINE && byte_stb && !is_trs && ph == 2'd0
		&& px == start_x;
	wire take     = line_go || (state == vcp_pkg::CAP_IN_LINE && byte_stb);
	wire [1:0] take_ph = line_go ? 2'd0 : cph;
	wire last_byte = state == vcp_pkg::CAP_IN_LINE && byte_stb && bytes_left == 1;
	wire line_end  = state == vcp_pkg::CAP_LINE_END;
	wire done_evt  = state == vcp_pkg::CAP_DRAIN && drained;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state      <= vcp_pkg::CAP_IDLE;
			lines_left <= '0;
			bytes_left <= '0;
			cph        <= '0;
		end else begin
			unique case (state)
			vcp_pkg::CAP_IDLE: if (cap_start) begin
				lines_left <= cap_height;
				state      <= vcp_pkg::CAP_WAIT_LINE;
			end
			vcp_pkg::CAP_WAIT_LINE: if (line_go) begin
				cph        <= 2'd1;
				bytes_left <= {cap_width, 1'b0} - 1'b1;
				state      <= vcp_pkg::CAP_IN_LINE;
			end
			vcp_pkg::CAP_IN_LINE: if (byte_stb) begin
				cph        <= cph + 2'd1;
				bytes_left <= bytes_left - 1'b1;
				if (last_byte)
					state <= chroma_siting_select ? vcp_pkg::CAP_EOL1 : vcp_pkg::CAP_LINE_END;
			end
			vcp_pkg::CAP_EOL1: state <= vcp_pkg::CAP_EOL2;
			vcp_pkg::CAP_EOL2: state <= vcp_pkg::CAP_LINE_END;
			vcp_pkg::CAP_LINE_END: begin
				lines_left <= lines_left - 1'b1;
				state <= (lines_left == 1) ? vcp_pkg::CAP_DRAIN : vcp_pkg::CAP_WAIT_LINE;
			end
			// completion waits for every word to be accepted
			vcp_pkg::CAP_DRAIN: if (drained)
				state <= vcp_pkg::CAP_IDLE;
			default: state <= vcp_pkg::CAP_IDLE;
			endcase
		end
	end

	// chroma siting: co-sited passes through, midway uses a 4-tap with lag of two
	logic [7:0] chist [2][3];
	logic [1:0] ccnt [2];
	logic [1:0] cf_vld;
	logic [7:0] cf_val [2];
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			cf_vld[c] = 1'b0;
			cf_val[c] = byte_in;
			if (!chroma_siting_select) begin
				cf_vld[c] = take && take_ph == 2'(2 * c);
			end else if (take && take_ph == 2'(2 * c) && ccnt[c] >= 2'd2) begin
				// midway; left edge mirrors around the first pixel
				cf_vld[c] = 1'b1;
				cf_val[c] = filt4((ccnt[c] == 2'd2) ? chist[c][0] : chist[c][2],
					chist[c][1], chist[c][0], byte_in);
			end else if (state == vcp_pkg::CAP_EOL1) begin
				// right edge mirrors around the last pixel
				cf_vld[c] = 1'b1;
				cf_val[c] = filt4(chist[c][2], chist[c][1], chist[c][0], chist[c][1]);
			end else if (state == vcp_pkg::CAP_EOL2) begin
				cf_vld[c] = 1'b1;
				cf_val[c] = filt4(chist[c][1], chist[c][0], chist[c][1], chist[c][2]);
			end
		end
	end

	// decimation and packing per plane
	logic [2:0] dec_vld;
	logic [7:0] dec_val [3];
	logic [7:0] keep [3];
	logic [2:0] dph;
	logic [2:0] push;
	logic [7:0] push_val [3];
	logic [31:0] bp [3];
	logic [31:0] acc [3];
	logic [31:0] put_data [3];
	logic [3:0]  put_be [3];
	logic [1:0]  pos [3];
	logic [2:0]  hand;
	logic [2:0]  grant;
	logic [1:0]  gsel;
	logic [2:0]  slot_busy;
	vcp_pkg::vcp_word_t pend_word [3];
	wire mem_free = !mem_req || mem_ack;

	always_comb begin
		dec_vld[0] = take & take_ph[0];
		dec_val[0] = byte_in;
		dec_vld[1] = cf_vld[0];
		dec_val[1] = cf_val[0];
		dec_vld[2] = cf_vld[1];
		dec_val[2] = cf_val[1];
		grant      = '0;
		gsel       = '0;
		for (int p = 0; p < 3; p++) begin
			// full resolution keeps every sample; half keeps the rounded mean of each pair
			push[p]     = ctl_halfres ? (dec_vld[p] & dph[p]) : dec_vld[p];
			push_val[p] = ctl_halfres ? avg_sat(keep[p], dec_val[p]) : dec_val[p];
			// byte lane by endianness; consecutive bytes
			pos[p]      = ctl_little ? bp[p][1:0] : ~bp[p][1:0];
			put_data[p] = acc[p];
			put_be[p]   = be_acc[p];
			if (push[p]) begin
				put_data[p][{pos[p], 3'b000} +: 8] = push_val[p];
				put_be[p][pos[p]] = 1'b1;
			end
			hand[p] = (push[p] && bp[p][1:0] == 2'd3) || (line_end && be_acc[p] != 4'h0);
			if (mem_free && pend_v[p] && grant == 3'b000) begin
				grant[p] = 1'b1;
				gsel     = 2'(p);
			end
			slot_busy[p] = pend_v[p] & ~grant[p];
		end
	end
	wire overflow = |(hand & slot_busy);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pend_v   <= '0;
			dph      <= '0;
			mem_req  <= 1'b0;
			mem_word <= '0;
			for (int p = 0; p < 3; p++) begin
				bp[p]        <= '0;
				acc[p]       <= '0;
				be_acc[p]    <= '0;
				keep[p]      <= '0;
				pend_word[p] <= '0;
			end
			for (int c = 0; c < 2; c++) begin
				ccnt[c]     <= '0;
				chist[c][0] <= '0;
				chist[c][1] <= '0;
				chist[c][2] <= '0;
			end
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (line_end)
					ccnt[c] <= '0;
				else if (take && take_ph == 2'(2 * c)) begin
					ccnt[c]     <= (ccnt[c] == 2'd3) ? 2'd3 : ccnt[c] + 2'd1;
					chist[c][0] <= byte_in;
					chist[c][1] <= chist[c][0];
					chist[c][2] <= chist[c][1];
				end
			end
			for (int p = 0; p < 3; p++) begin
				if (line_end)
					dph[p] <= 1'b0;
				else if (dec_vld[p]) begin
					dph[p]  <= ~dph[p];
					keep[p] <= dec_val[p];
				end
				if (grant[p])
					pend_v[p] <= 1'b0;
				if (cap_start) begin
					// pointers load from base only at image start
					bp[p]     <= base_adr[p];
					acc[p]    <= '0;
					be_acc[p] <= '0;
				end else begin
					if (push[p])
						bp[p] <= bp[p] + 32'd1;
					// live line step applied at each line end
					if (line_end)
						bp[p] <= bp[p] - 32'd1 + {16'h0000, line_step[p]};
					if (hand[p]) begin
						acc[p]    <= '0;
						be_acc[p] <= '0;
						// a word that finds its slot full is dropped, address still advances
						if (!slot_busy[p]) begin
							pend_v[p]    <= 1'b1;
							pend_word[p] <= '{addr: {bp[p][31:2], 2'b00}, data: put_data[p],
								be: put_be[p]};
						end
					end else if (push[p]) begin
						acc[p]    <= put_data[p];
						be_acc[p] <= put_be[p];
					end
				end
			end
			// words leave at each line end, so an alert waits only on memory
			if (mem_free) begin
				mem_req <= |grant;
				if (|grant)
					mem_word <= pend_word[gsel];
			end
		end
	end

	// event flags: a set in the same cycle as its acknowledge wins
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			done_flag            <= 1'b0;
			alert_flag           <= 1'b0;
			bandwidth_fault_flag <= 1'b0;
		end else begin
			// completion set after drain, acknowledge clears and re-arms
			done_flag            <= done_evt | (done_flag & ~ack_done);
			alert_flag           <= alert_evt | (alert_flag & ~ack_alert);
			bandwidth_fault_flag <= overflow | (bandwidth_fault_flag & ~ack_fault);
		end
	end

	// one level request from the enabled flags
	assign irq = (done_flag & control[vcp_pkg::CB_IE_DONE])
		| (alert_flag & control[vcp_pkg::CB_IE_ALERT])
		| (bandwidth_fault_flag & control[vcp_pkg::CB_IE_FAULT]);

	a_start_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
		state == vcp_pkg::CAP_IDLE && !cap_start |=> state == vcp_pkg::CAP_IDLE)
		else $error("capture left idle without its start conditions");
	a_base_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
		cap_start |=> bp[0] == $past(base_adr[0]) && bp[0][5:0] == 6'h00)
		else $error("luma pointer not loaded from aligned base");
	a_pack_order: assert property (@(posedge clk_sys) disable iff (!rst_b)
		push[0] && !ctl_little && bp[0][1:0] == 2'd0 && !cap_start
		|=> acc[0][31:24] == $past(push_val[0]) && bp[0][1:0] == 2'd1)
		else $error("big-endian first byte not in top lane");
	a_line_step: assert property (@(posedge clk_sys) disable iff (!rst_b)
		line_end |=> bp[1] == $past(bp[1]) - 32'd1 + {16'h0000, $past(line_step[1])})
		else $error("line step not applied at line end");
	a_done_drain: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(done_flag) |-> $past(drained) && pend_v == 3'b000)
		else $error("completion raised before memory drained");
	a_field_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!vblank_start |=> $stable(second_field_flag))
		else $error("field flag moved outside vertical blanking start");
	a_alert_ack: assert property (@(posedge clk_sys) disable iff (!rst_b)
		alert_flag && !alert_evt |=> alert_flag == !$past(ack_alert))
		else $error("alert flag acknowledge misbehaved");
	a_alert_drain: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(alert_flag) && state != vcp_pkg::CAP_IN_LINE
		|-> ##[0:ALERT_DRAIN_CYC] (pend_v == 3'b000 && !mem_req))
		else $error("writes still pending long after line alert");
	a_fault_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
		overflow |=> bandwidth_fault_flag ##1 (bandwidth_fault_flag || $past(ack_fault)))
		else $error("overflow did not set sticky fault");
	a_irq_drop: assert property (@(posedge clk_sys) disable iff (!rst_b)
		ctl_wr && pwdata[10:8] == 3'b111 && !done_evt && !alert_evt && !overflow |=> !irq)
		else $error("interrupt request held after all flags cleared");
	a_sat_range: assert property (@(posedge clk_sys) disable iff (!rst_b)
		push[1] && (chroma_siting_select || ctl_halfres) |-> push_val[1] != 8'h00)
		else $error("filtered chroma below clamp floor");
endmodule

// ### verif/vcp_cam.sv
`timescale 1ns/1ns
module vcp_cam (
	// camera pins
	output logic       vid_clk,
	output logic       vid_dvalid,
	output logic [7:0] vid_data
);
	initial begin
		vid_clk = 0;
		vid_dvalid = 0;
		vid_data = 8'h5A;
	end
	// data moves on the falling edge, so it is settled 80 ns either side of a rise;
	// non-blocking, since pin edges land on system clock edges and would race the sampler
	task automatic put(input logic [7:0] d);
		vid_data <= d;
		vid_dvalid <= 1;
		#80 vid_clk <= 1;
		#80 vid_clk <= 0;
	endtask
	task automatic code(input logic [7:0] xy);
		put(8'hFF);
		put(8'h00);
		put(8'h00);
		put(xy);
	endtask
	// clock stands still between lines; data shows the inverse of its last value
	task automatic line(input logic f, input logic v, input logic [63:0] pv);
		code({1'b1, f, v, 5'h00});
		for (int k = 0; k < 8; k++) put(pv[8*k+:8]);
		code({1'b1, f, v, 5'h10});
		vid_dvalid <= 0;
		vid_data <= ~vid_data;
	endtask
endmodule

// ### verif/vcp_capture_test.sv
`timescale 1ns/1ns
module vcp_capture_test;
	logic               clk_sys = 0;
	logic               rst_b = 0;
	logic               psel = 0, penable = 0, pwrite = 0, mem_ack = 0;
	logic               pready, pslverr, mem_req, irq, err, vid_clk, vid_dvalid;
	logic        [11:0] paddr = 0;
	logic        [31:0] pwdata = 0, prdata, rd, m, c;
	logic        [7:0]  vid_data, b[8];
	logic        [15:0] seed = 16'd58321, aseed = 16'd58321;
	logic        [63:0] pv;
	vcp_pkg::vcp_word_t mem_word, w;
	vcp_pkg::vcp_word_t exp_q[3][$];
	int                 error_cnt = 0, n_compared = 0, p;

	always #5 clk_sys = ~clk_sys;

	vcp_capture DUT (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .vid_clk, .vid_dvalid, .vid_data, .mem_req, .mem_word, .mem_ack, .irq);
	vcp_cam cam (.vid_clk, .vid_dvalid, .vid_data);

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [31:0] pack(input int e, input logic [7:0] a, x, y, z);
		return e ? {z, y, x, a} : {a, x, y, z};
	endfunction
	// pair average rounds half up; samples are never below 01h, so neither is the mean
	function automatic logic [7:0] av(input int x, input int y);
		return 8'((x + y + 1) / 2);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask
	task automatic tally_and_finish;
		$display("errors=%0d compared=%0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic frame(input int e);
		logic [7:0] s[4];
		int         h;
		int         n;
		h = e == 3;
		for (int l = -1; l < 4; l++) begin
			for (int k = 0; k < 8; k++) begin
				seed = lfsr(seed);
				b[k] = 8'(seed % 254 + 1);
				pv[8*k+:8] = b[k];
			end
			// base start, packed bytes, next line one step past last byte
			// half resolution keeps pair averages: two luma, one chroma per line
			for (int q = 0; q < 3 && e != 2 && l > 1; q++) begin
				n = (q ? 2 : 4) >> h;
				if (q == 0 && h)
					s = '{av(b[1], b[3]), av(b[5], b[7]), 0, 0};
				else if (q == 0)
					s = '{b[1], b[3], b[5], b[7]};
				else if (h)
					s = '{av(b[2*q-2], b[2*q+2]), 0, 0, 0};
				else
					s = '{b[2*q-2], b[2*q+2], 0, 0};
				exp_q[q].push_back('{32'((q + 1) << 12) + 32'(64 * (l - 2)),
					pack(e, s[0], s[1], s[2], s[3]),
					e ? 4'((1 << n) - 1) : 4'(15 << (4 - n))});
			end
			cam.line(1'(e), l < 0, pv);
			#400;
		end
	endtask

	always @(posedge clk_sys) begin
		if (mem_req && mem_ack) begin
			p = int'(mem_word.addr[13:12]) - 1;
			if (p < 0 || exp_q[p].size() == 0)
				chk(mem_word.addr, 0);
			else begin
				w = exp_q[p].pop_front();
				m = {{8{w.be[3]}}, {8{w.be[2]}}, {8{w.be[1]}}, {8{w.be[0]}}};
				chk(mem_word.addr, w.addr);
				chk(32'(mem_word.be), 32'(w.be));
				chk(mem_word.data & m, w.data & m);
			end
		end
		mem_ack <= mem_req && !mem_ack && aseed[0];
		aseed <= lfsr(aseed);
	end

	initial begin
		#300000;
		error_cnt++;
		tally_and_finish;
	end

	initial begin
		repeat (4) @(posedge clk_sys);
		rst_b <= 1;
		apb(0, vcp_pkg::OFS_CONTROL, 0);
		chk(rd, 0);
		for (int i = 0; i < 3; i++) begin
			// steps keep line starts 64-byte aligned
			apb(1, vcp_pkg::OFS_STEP_Y + 12'(8 * i), i ? 63 : 61);
			apb(1, vcp_pkg::OFS_BASE_Y + 12'(8 * i), 32'((i + 1) << 12) | 32'h3F);
			apb(0, vcp_pkg::OFS_BASE_Y + 12'(8 * i), 0);
			chk(rd, 32'((i + 1) << 12));
		end
		// the first blanking line after reset already counts as line 1, so start at line 2
		apb(1, vcp_pkg::OFS_CAP_START, 32'h0002_0000);
		// first column 0 and width 4 are multiples of four for half resolution
		apb(1, vcp_pkg::OFS_CAP_SIZE, 32'h0002_0004);
		apb(1, vcp_pkg::OFS_LINE_ALERT, 32'h0000_0003);
		apb(1, 12'h0FC, 0);
		chk(32'(err), 1);
		for (int e = 0; e < 4; e++) begin
			c = e == 2 ? 0 : 32'h11 | 32'(e << 1);
			// half resolution stores fewer bytes, so steps grow to keep 64-byte starts
			for (int i = 0; i < 3 && e == 3; i++)
				apb(1, vcp_pkg::OFS_STEP_Y + 12'(8 * i), i ? 64 : 63);
			apb(1, vcp_pkg::OFS_CONTROL, c);
			frame(e);
			for (int i = 0; i < 600 && irq !== 1'b1 && e != 2; i++) @(posedge clk_sys);
			chk(32'(irq), 32'(e != 2));
			apb(0, vcp_pkg::OFS_STATUS, 0);
			chk(rd & 32'hF, 32'(e != 2 ? 3 : 2) | 32'((e & 1) << 3));
			chk(32'(exp_q[0].size() + exp_q[1].size() + exp_q[2].size()), 0);
			apb(1, vcp_pkg::OFS_CONTROL, c | 32'h700);
			#1 chk(32'(irq), 0);
			apb(0, vcp_pkg::OFS_STATUS, 0);
			chk(rd & 32'h7, 0);
		end
		tally_and_finish;
	end
endmodule
